// ===== src/amp_mode_fault_control.sv
// The address map and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
module amp_mode_fault_control import amp_pkg::*; #(
  parameter int PULSE_PERIOD = PULSE_PERIOD_CYC,
  parameter int DC_RECOVER = DC_RECOVER_CYC,
  parameter int HEAT_RECOVER = HEAT_RECOVER_CYC
) (
  // clock and core supply reset
  input wire logic REF_CLK,
  input wire logic RST_B,
  // apb slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // pins and analog monitors, asynchronous
  input wire logic SHUTDOWN_N,
  input wire logic FRAME_CLK,
  input wire logic SUPPLY_OK,
  input wire logic OVERTEMP_DET,
  input wire logic DC_DET,
  input wire logic OVERCURRENT_DET,
  // audio datapath, same clock
  input wire logic SAMPLE_ZERO,
  input wire logic CLK_RATE_ERR,
  // open-drain fault pin
  input wire logic FAULT_OUT_N_IN,
  output logic FAULT_OUT_N_OUT,
  output logic FAULT_OUT_N_OE_N,
  output logic FAULT_PULLUP_EN,
  // power stage and volume
  output logic SWITCH_EN,
  output logic STAGE_HIZ,
  output logic BLOCKS_ON,
  output logic [1:0] CURRENT_LIMIT,
  output logic [7:0] VOLUME_LEVEL
);
  logic [6:0] sy;
  logic sd_pin_n, fclk_s, supply_ok, ot_det, dc_det, oc_det, pin_lvl;
  logic [7:0] power_r, ctrl2_r, volume_r, ctrl3_r, analog2_r;
  logic [3:0] fault_cfg_r;
  logic pready_r, pslverr_r;
  logic [31:0] prdata_r, rdata;
  logic [7:0] idx;
  logic apb_acc, wr_fire;
  mode_t state_r;
  latched_t flags_r, set_vec;
  logic supply_seen_r, sd_user_d_r, fclk_d_r, clk_err_r, active_once_r;
  logic auto_r, down_to_shut_r, fault_drive;
  logic sd_user, sd_req, clear_pulse, sample_tick, ramp_tick, halted;
  logic hard_sleep, sleep_bit, auto_idle, rec_busy, pulse_low;
  logic [25:0] rec_cnt_r;
  logic [13:0] pulse_cnt_r;
  logic [11:0] halt_cnt_r, start_cnt_r;
  logic [15:0] idle_cnt_r, idle_lim;
  logic [2:0] ramp_div_r;
  logic [7:0] level_r, target;

  function automatic logic [15:0] idle_limit(input logic [1:0] code);
    case (code)
      2'b01: idle_limit = IDLE_SAMPLES_1;
      2'b10: idle_limit = IDLE_SAMPLES_2;
      2'b11: idle_limit = IDLE_SAMPLES_3;
      default: idle_limit = 16'h0000;
    endcase
  endfunction

  function automatic logic reg_hit(input logic [7:0] i);
    reg_hit = (i == IDX_POWER) || (i == IDX_CTRL2) || (i == IDX_VOLUME) ||
      (i == IDX_FAULT) || (i == IDX_CTRL3) || (i == IDX_ANALOG2) ||
      (i == IDX_STATUS);
  endfunction

  sync2 #(.W(7)) u_sync (
    .clk(REF_CLK),
    .rst_b(RST_B),
    .d({SHUTDOWN_N, FRAME_CLK, SUPPLY_OK, OVERTEMP_DET, DC_DET,
        OVERCURRENT_DET, FAULT_OUT_N_IN}),
    .q(sy)
  );
  assign {sd_pin_n, fclk_s, supply_ok, ot_det, dc_det, oc_det, pin_lvl} = sy;

  // ---------------- apb slave: one wait state, then PREADY
  assign idx = {2'b00, PADDR[7:2]};
  assign apb_acc = PSEL & PENABLE;
  assign wr_fire = apb_acc & pready_r & PWRITE;

  always_comb begin
    rdata = 32'h0000_0000;
    case (idx)
      IDX_POWER: rdata[7:0] = power_r;
      IDX_CTRL2: rdata[7:0] = ctrl2_r;
      IDX_VOLUME: rdata[7:0] = volume_r;
      IDX_FAULT: rdata[7:0] = {fault_cfg_r,
        (state_r == ST_SHUT) | clk_err_r, flags_r}; // RULE12 RULE13
      IDX_CTRL3: rdata[7:0] = ctrl3_r;
      IDX_ANALOG2: rdata[7:0] = analog2_r;
      IDX_STATUS: rdata[8:0] = {pin_lvl, SWITCH_EN, supply_seen_r,
        rec_busy, auto_r, active_once_r, state_r};
      default: rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
    end else begin
      pready_r <= apb_acc & ~pready_r;
      if (apb_acc & ~pready_r) begin
        pslverr_r <= ~reg_hit(idx) | (PADDR[1:0] != 2'b00);
        prdata_r <= PWRITE ? 32'h0000_0000 : rdata;
      end
    end
  end
  assign PREADY = pready_r;
  assign PSLVERR = pslverr_r;
  assign PRDATA = prdata_r;

  // defaults reload only on core supply reset; reserved bits are stored
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      power_r <= POWER_RST; // RULE9 RULE22
      ctrl2_r <= CTRL2_RST;
      volume_r <= VOLUME_RST;
      fault_cfg_r <= FAULT_CFG_RST;
      ctrl3_r <= CTRL3_RST;
      analog2_r <= ANALOG2_RST;
    end else if (wr_fire && PADDR[1:0] == 2'b00) begin
      case (idx)
        IDX_POWER: power_r <= PWDATA[7:0];
        IDX_CTRL2: ctrl2_r <= PWDATA[7:0];
        IDX_VOLUME: volume_r <= PWDATA[7:0];
        IDX_FAULT: fault_cfg_r <= PWDATA[7:4];
        IDX_CTRL3: ctrl3_r <= PWDATA[7:0];
        IDX_ANALOG2: analog2_r <= PWDATA[7:0];
        default: ;
      endcase
    end
  end

  // ---------------- shutdown request and fault clearing
  assign sd_user = ~sd_pin_n | ~power_r[PWR_SDZ_BIT]; // RULE23
  assign sd_req = sd_user | ~supply_seen_r; // RULE10
  // clear on the release edge, so a full low-high toggle is needed
  assign clear_pulse = sd_user_d_r & ~sd_user; // RULE20 RULE25

  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      supply_seen_r <= 1'b0;
      sd_user_d_r <= 1'b1;
    end else begin
      sd_user_d_r <= sd_user;
      if (supply_ok) begin
        supply_seen_r <= 1'b1; // RULE10
      end
    end
  end

  // detectors are powered only outside shutdown; a new set beats a clear
  assign set_vec = (state_r == ST_SHUT) ? 3'b000 : {oc_det, dc_det, ot_det};

  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      flags_r <= 3'b000;
    end else begin
      flags_r <= (flags_r & ~{3{clear_pulse}}) | set_vec; // RULE16 RULE17 RULE18 RULE20
    end
  end

  assign rec_busy = rec_cnt_r != 26'd0;

  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      rec_cnt_r <= 26'd0;
    end else if (clear_pulse && (flags_r.overtemp || flags_r.overcurrent)) begin
      rec_cnt_r <= 26'(HEAT_RECOVER - 1); // RULE21
    end else if (clear_pulse && flags_r.dc_offset) begin
      rec_cnt_r <= 26'(DC_RECOVER - 1); // RULE21
    end else if (rec_busy) begin
      rec_cnt_r <= rec_cnt_r - 26'd1;
    end
  end

  // ---------------- audio clock supervision
  assign sample_tick = fclk_s & ~fclk_d_r;
  assign halted = halt_cnt_r == 12'(HALT_CYC);

  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      fclk_d_r <= 1'b0;
      halt_cnt_r <= 12'd0;
      clk_err_r <= 1'b0;
    end else begin
      fclk_d_r <= fclk_s;
      // detector is powered down in shutdown
      if (state_r == ST_SHUT || sample_tick) begin
        halt_cnt_r <= 12'd0; // RULE13
      end else if (!halted) begin
        halt_cnt_r <= halt_cnt_r + 12'd1;
      end
      clk_err_r <= (state_r != ST_SHUT) & (CLK_RATE_ERR | halted); // RULE11
    end
  end

  assign pulse_low = pulse_cnt_r < 14'(PULSE_LOW_CYC);

  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      pulse_cnt_r <= 14'd0;
      active_once_r <= 1'b0;
    end else begin
      if (!clk_err_r || pulse_cnt_r == 14'(PULSE_PERIOD - 1)) begin
        pulse_cnt_r <= 14'd0; // RULE14
      end else begin
        pulse_cnt_r <= pulse_cnt_r + 14'd1;
      end
      if (state_r == ST_SHUT) begin
        active_once_r <= 1'b0;
      end else if (state_r == ST_PLAY) begin
        active_once_r <= 1'b1;
      end
    end
  end

  // pulsed mode avoids a lock-up when the pin loops back to shutdown
  assign fault_drive = (|flags_r) | rec_busy | // RULE19 RULE21
    (clk_err_r & (active_once_r | pulse_low)); // RULE12 RULE14 RULE15

  // ---------------- idle run for auto-sleep
  assign idle_lim = idle_limit(ctrl3_r[IDLE_LSB +: 2]);
  assign auto_idle = (idle_lim != 16'h0000) && (idle_cnt_r == idle_lim); // RULE5

  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      idle_cnt_r <= 16'h0000;
    end else if (state_r == ST_SHUT || (sample_tick && !SAMPLE_ZERO)) begin
      idle_cnt_r <= 16'h0000; // RULE6
    end else if (sample_tick && !auto_idle) begin
      idle_cnt_r <= idle_cnt_r + 16'h0001;
    end
  end

  // ---------------- mode controller
  assign sleep_bit = power_r[PWR_SLEEP_BIT];
  // events that cut switching at once, without a ramp
  assign hard_sleep = ~supply_ok | clk_err_r | (|flags_r) | rec_busy; // RULE10 RULE11

  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      state_r <= ST_SHUT; // RULE9
      start_cnt_r <= 12'd0;
      down_to_shut_r <= 1'b0;
      auto_r <= 1'b0;
    end else begin
      case (state_r)
        ST_SHUT: begin
          auto_r <= 1'b0;
          start_cnt_r <= 12'd0;
          if (!sd_req) begin
            state_r <= ST_START;
          end
        end
        ST_START: begin
          start_cnt_r <= start_cnt_r + 12'd1;
          if (sd_req) begin
            state_r <= ST_SHUT;
          end else if (start_cnt_r == 12'(STARTUP_CYC - 1)) begin
            state_r <= (hard_sleep | sleep_bit) ? ST_SLEEP : ST_PLAY; // RULE2
          end
        end
        ST_PLAY: begin
          // shutdown first, then sleep; mute only shapes the ramp
          if (sd_req) begin
            state_r <= ST_RAMPDN; // RULE24 RULE26
            down_to_shut_r <= 1'b1;
          end else if (hard_sleep) begin
            state_r <= ST_SLEEP; // RULE11 RULE16 RULE17 RULE18
          end else if (sleep_bit) begin
            state_r <= ST_RAMPDN; // RULE4
            down_to_shut_r <= 1'b0;
          end else if (auto_idle) begin
            state_r <= ST_SLEEP; // RULE6
            auto_r <= 1'b1;
          end
        end
        ST_RAMPDN: begin
          if (sd_req) begin
            down_to_shut_r <= 1'b1;
          end
          if (!sd_req && hard_sleep) begin
            state_r <= ST_SLEEP;
          end else if (!sd_req && !sleep_bit) begin
            state_r <= ST_PLAY; // RULE7
          // a halted frame clock would stall the ramp forever
          end else if (level_r == 8'h00 || clk_err_r) begin
            state_r <= down_to_shut_r | sd_req ? ST_SHUT : ST_SLEEP; // RULE24
          end
        end
        ST_SLEEP: begin
          if (sd_req) begin
            state_r <= ST_SHUT; // RULE26
          end else if (hard_sleep || sleep_bit) begin
            auto_r <= 1'b0; // RULE1
          end else if (!auto_r || !auto_idle) begin
            state_r <= ST_PLAY; // RULE6 RULE7 RULE11
            auto_r <= 1'b0;
          end
        end
        default: state_r <= ST_SHUT;
      endcase
    end
  end

  // ---------------- volume ramp, one step per sample or per eight
  assign ramp_tick = sample_tick & (ctrl2_r[CTRL2_SPEED_BIT] |
    (ramp_div_r == 3'(SLOW_STEP_SAMPLES - 1))); // RULE3
  assign target = ctrl2_r[CTRL2_MUTE_BIT] ? 8'h00 : volume_r; // RULE8

  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      ramp_div_r <= 3'd0;
      level_r <= 8'h00;
    end else begin
      if (sample_tick) begin
        ramp_div_r <= ramp_div_r + 3'd1;
      end
      if (state_r == ST_SHUT || (state_r == ST_SLEEP && !auto_r)) begin
        level_r <= 8'h00; // RULE1 RULE2
      end else if (ramp_tick && state_r == ST_PLAY) begin
        if (level_r < target) begin
          level_r <= level_r + 8'h01; // RULE2 RULE3
        end else if (level_r > target) begin
          level_r <= level_r - 8'h01; // RULE8
        end
      end else if (ramp_tick && state_r == ST_RAMPDN && level_r != 8'h00) begin
        level_r <= level_r - 8'h01; // RULE4 RULE24
      end
    end
  end

  // ---------------- registered outputs
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      SWITCH_EN <= 1'b0;
      STAGE_HIZ <= 1'b1;
      BLOCKS_ON <= 1'b0;
      FAULT_OUT_N_OUT <= 1'b0;
      FAULT_OUT_N_OE_N <= 1'b1;
      FAULT_PULLUP_EN <= 1'b0;
      CURRENT_LIMIT <= 2'b00;
      VOLUME_LEVEL <= 8'h00;
    end else begin
      // muted play keeps switching with idle input
      SWITCH_EN <= state_r == ST_PLAY || state_r == ST_RAMPDN; // RULE1 RULE8
      STAGE_HIZ <= !(state_r == ST_PLAY || state_r == ST_RAMPDN); // RULE24
      BLOCKS_ON <= state_r != ST_SHUT; // RULE1 RULE24
      FAULT_OUT_N_OUT <= 1'b0;
      FAULT_OUT_N_OE_N <= ~fault_drive; // RULE19
      FAULT_PULLUP_EN <= analog2_r[ANALOG2_PU_BIT]; // RULE19
      CURRENT_LIMIT <= fault_cfg_r[FAULT_LIMIT_LSB - 4 +: 2]; // RULE18
      VOLUME_LEVEL <= level_r;
    end
  end
endmodule

// ===== src/amp_pkg.sv
// Function
// (RULE1) sleep stops switching, keeps restart logic up, latched faults stay set
// (RULE2) on shutdown release without sleep: start delay, then ramp volume up
// (RULE3) ramp length follows volume setting, sample rate and speed select
// (RULE4) sleep, mute and shutdown transitions are paced by the volume ramp
// (RULE5) auto-sleep enters sleep after a run of zero samples, length programmable
// (RULE6) first nonzero sample wakes auto-sleep at once; no ramp on entry
// (RULE7) active whenever neither shutdown nor sleep is in effect
// (RULE8) mute ramps volume down while the power stage keeps switching
// (RULE9) core supply reset releases registers; it is the only reset
// (RULE10) stay shut until stage supply first valid; later dips force sleep
// (RULE11) clock errors force immediate sleep; recovery ramps back to playback
// (RULE12) during a clock error fault pin low and clock error flag set
// (RULE13) in shutdown clock error detection is off and its flag reads 1
// (RULE14) before first active entry clock errors pulse fault pin periodically
// (RULE15) after first active entry clock errors hold fault pin low
// (RULE16) over-temperature forces sleep and latches its flag at bit 0
// (RULE17) output DC content forces sleep and latches its flag at bit 1
// (RULE18) overcurrent above selected limit forces sleep, latches flag bit 2
// (RULE19) fault pin held low while any latched fault; optional pull-up
// (RULE20) only a shutdown toggle clears the three latched flags
// (RULE21) after clear wait 650 ms (DC) or 1.3 s before release
// (RULE22) host writes reserved bits with defaults; defaults reload at reset
// (RULE23) shutdown when pin low or control bit 0; registers kept
// (RULE24) shutdown during playback ramps down, stops switching, powers down
// (RULE25) host clears a fault by driving shutdown low then high
// (RULE26) shutdown outranks sleep, which outranks mute
package amp_pkg;
  localparam int CLK_KHZ = 40000;
  localparam int PULSE_LOW_US = 10;
  localparam int PULSE_LOW_CYC = (PULSE_LOW_US * CLK_KHZ + 999) / 1000;
  localparam int PULSE_PERIOD_US = 350;
  localparam int PULSE_PERIOD_CYC = (PULSE_PERIOD_US * CLK_KHZ) / 1000;
  localparam int DC_RECOVER_MS = 650;
  localparam int DC_RECOVER_CYC = DC_RECOVER_MS * CLK_KHZ;
  localparam int HEAT_RECOVER_MS = 1300;
  localparam int HEAT_RECOVER_CYC = HEAT_RECOVER_MS * CLK_KHZ;
  localparam int STARTUP_US = 100;
  localparam int STARTUP_CYC = (STARTUP_US * CLK_KHZ + 999) / 1000;
  localparam int HALT_US = 50;
  localparam int HALT_CYC = (HALT_US * CLK_KHZ + 999) / 1000;
  localparam int SLOW_STEP_SAMPLES = 8;
  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_POWER = 8'h01;
  localparam logic [7:0] IDX_CTRL2 = 8'h03;
  localparam logic [7:0] IDX_VOLUME = 8'h04;
  localparam logic [7:0] IDX_FAULT = 8'h08;
  localparam logic [7:0] IDX_CTRL3 = 8'h13;
  localparam logic [7:0] IDX_ANALOG2 = 8'h14;
  localparam logic [7:0] IDX_STATUS = 8'h20;
  localparam logic [7:0] POWER_RST = 8'hFD;
  localparam logic [7:0] CTRL2_RST = 8'h80;
  localparam logic [7:0] VOLUME_RST = 8'hCF;
  localparam logic [3:0] FAULT_CFG_RST = 4'h0;
  localparam logic [7:0] CTRL3_RST = 8'h00;
  localparam logic [7:0] ANALOG2_RST = 8'h02;
  localparam int PWR_SDZ_BIT = 0;
  localparam int PWR_SLEEP_BIT = 1;
  localparam int CTRL2_MUTE_BIT = 4;
  localparam int CTRL2_SPEED_BIT = 6;
  localparam int FAULT_CLKERR_BIT = 3;
  localparam int FAULT_LIMIT_LSB = 4;
  localparam int IDLE_LSB = 3;
  localparam int ANALOG2_PU_BIT = 3;
  localparam logic [15:0] IDLE_SAMPLES_1 = 16'h0400;
  localparam logic [15:0] IDLE_SAMPLES_2 = 16'h1000;
  localparam logic [15:0] IDLE_SAMPLES_3 = 16'h4000;

  typedef enum logic [2:0] {
    ST_SHUT = 3'b000,
    ST_START = 3'b001,
    ST_PLAY = 3'b010,
    ST_RAMPDN = 3'b011,
    ST_SLEEP = 3'b100
  } mode_t;

  // latched protection faults, bit order as in the fault register
  typedef struct packed {
    logic overcurrent;
    logic dc_offset;
    logic overtemp;
  } latched_t;
endpackage

// ===== src/sync2.sv
`timescale 1ns/1ps
module sync2 #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_r;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_r <= '0;
      q <= '0;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule

// ===== tb/amp_monitor.sv
`timescale 1ns/1ps
module amp_monitor (
  // clock and reset
  input wire logic REF_CLK,
  input wire logic RST_B,
  // bus
  input wire logic PWRITE,
  input wire logic PREADY,
  // monitors
  input wire logic CLK_RATE_ERR,
  input wire logic OVERTEMP_DET,
  input wire logic DC_DET,
  input wire logic OVERCURRENT_DET,
  // fault pin and stage
  input wire logic FAULT_OUT_N_OUT,
  input wire logic FAULT_OUT_N_OE_N,
  input wire logic SWITCH_EN,
  input wire logic STAGE_HIZ,
  input wire logic BLOCKS_ON,
  input wire logic [1:0] CURRENT_LIMIT,
  input wire logic [7:0] VOLUME_LEVEL
);
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RST_B);
  wire det_any = OVERTEMP_DET | DC_DET | OVERCURRENT_DET;

  property p_hiz;
    STAGE_HIZ == !SWITCH_EN;
  endproperty
  a_hiz: assert property (p_hiz)
    else $error("stage hiz differs from switching");
  property p_shut;
    !BLOCKS_ON |-> !SWITCH_EN && STAGE_HIZ;
  endproperty
  a_shut: assert property (p_shut)
    else $error("switching while powered down");
  property p_start;
    $rose(BLOCKS_ON) |-> !SWITCH_EN [*8];
  endproperty
  a_start: assert property (p_start)
    else $error("switching without start delay");
  property p_step;
    SWITCH_EN && $past(SWITCH_EN) && VOLUME_LEVEL > $past(VOLUME_LEVEL)
      |-> VOLUME_LEVEL == $past(VOLUME_LEVEL) + 8'h01;
  endproperty
  a_step: assert property (p_step)
    else $error("volume jumped by more than one step");
  property p_clkerr;
    CLK_RATE_ERR && SWITCH_EN |-> ##[1:5] !SWITCH_EN;
  endproperty
  a_clkerr: assert property (p_clkerr)
    else $error("clock error did not stop switching");
  property p_prot;
    $rose(det_any) && BLOCKS_ON |-> ##[1:8] !SWITCH_EN;
  endproperty
  a_prot: assert property (p_prot)
    else $error("protection fault did not stop switching");
  property p_pin;
    $rose(det_any) && BLOCKS_ON |-> ##8 !FAULT_OUT_N_OE_N [*8];
  endproperty
  a_pin: assert property (p_pin)
    else $error("fault pin not held low");
  property p_odrain;
    FAULT_OUT_N_OUT == 1'b0;
  endproperty
  a_odrain: assert property (p_odrain)
    else $error("fault pin drives high");
  property p_limit;
    $changed(CURRENT_LIMIT)
      |-> $past(PWRITE && PREADY) || $past(PWRITE && PREADY, 2);
  endproperty
  a_limit: assert property (p_limit)
    else $error("current limit changed without a write");
  c_switch: cover property ($rose(SWITCH_EN));
  c_fault: cover property ($fell(FAULT_OUT_N_OE_N));
  c_write: cover property (PREADY && PWRITE);
endmodule

bind amp_mode_fault_control amp_monitor u_amp_monitor (
  .REF_CLK(REF_CLK), .RST_B(RST_B), .PWRITE(PWRITE), .PREADY(PREADY),
  .CLK_RATE_ERR(CLK_RATE_ERR), .OVERTEMP_DET(OVERTEMP_DET),
  .DC_DET(DC_DET), .OVERCURRENT_DET(OVERCURRENT_DET),
  .FAULT_OUT_N_OUT(FAULT_OUT_N_OUT), .FAULT_OUT_N_OE_N(FAULT_OUT_N_OE_N),
  .SWITCH_EN(SWITCH_EN), .STAGE_HIZ(STAGE_HIZ), .BLOCKS_ON(BLOCKS_ON),
  .CURRENT_LIMIT(CURRENT_LIMIT), .VOLUME_LEVEL(VOLUME_LEVEL)
);

// ===== tb/audio_source.sv
`timescale 1ns/1ps
module audio_source (
  // bench control
  input wire logic clk,
  input wire logic run,
  input wire logic zero,
  // toward the amplifier
  output logic frame_clk,
  output logic sample_zero
);
  // odd offset keeps frame edges away from clock edges; stops low on halt
  initial begin
    frame_clk = 1'b0;
    #37;
    forever begin
      #100;
      frame_clk = run ? ~frame_clk : 1'b0;
    end
  end
  initial sample_zero = 1'b0;
  always @(posedge clk) begin
    sample_zero <= zero;
  end
endmodule

// ===== tb/testbench.sv
`timescale 1ns/1ps
module testbench import amp_pkg::*;;
  localparam int DC_REC = 300;
  localparam int HEAT_REC = 600;
  logic ref_clk, rst_b, psel, penable, pwrite, shutdown_n, supply_ok;
  logic ot_det, dc_det, oc_det, rate_err, run, zero, frame_clk, smp_zero;
  logic pready, slverr, slverr_seen, oe_n, od_out, pu_en, sw_en, hiz, on;
  logic [1:0] cur_lim;
  logic [7:0] paddr, level;
  logic [31:0] pwdata, prdata, rd_d;
  int n_mismatch, checks, seed, n, m, vol;
  // board pull-up on the fault line
  wire pin = oe_n ? 1'b1 : 1'b0;

  amp_mode_fault_control #(.PULSE_PERIOD(1000), .DC_RECOVER(DC_REC),
    .HEAT_RECOVER(HEAT_REC)) u_amp_mode_fault_control (
    .REF_CLK(ref_clk), .RST_B(rst_b), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(slverr), .SHUTDOWN_N(shutdown_n),
    .FRAME_CLK(frame_clk), .SUPPLY_OK(supply_ok), .OVERTEMP_DET(ot_det),
    .DC_DET(dc_det), .OVERCURRENT_DET(oc_det), .SAMPLE_ZERO(smp_zero),
    .CLK_RATE_ERR(rate_err), .FAULT_OUT_N_IN(pin), .FAULT_OUT_N_OUT(od_out),
    .FAULT_OUT_N_OE_N(oe_n), .FAULT_PULLUP_EN(pu_en), .SWITCH_EN(sw_en),
    .STAGE_HIZ(hiz), .BLOCKS_ON(on), .CURRENT_LIMIT(cur_lim),
    .VOLUME_LEVEL(level));
  audio_source u_audio_source (.clk(ref_clk), .run(run), .zero(zero),
    .frame_clk(frame_clk), .sample_zero(smp_zero));

  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic ok(input logic c);
    chk({31'h0, c}, 32'h1);
  endtask
  task automatic apb(input logic w, input logic [7:0] idx,
                     input logic [31:0] d, output logic [31:0] r);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {idx[5:0], 2'b00};
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
    end while (pready !== 1'b1);
    r = prdata;
    slverr_seen = slverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    apb(1'b1, idx, {24'h0, d}, rd_d);
  endtask
  task automatic rd(input logic [7:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 32'h0, rd_d);
    chk(rd_d, exp);
  endtask
  // sel 0 switching, 1 volume level, 2 fault enable
  task automatic wait_on(input int sel, input logic [7:0] v, input int mx,
                         output int k);
    logic [7:0] cur;
    k = 0;
    forever begin
      cur = sel == 1 ? level : {7'h0, sel == 0 ? sw_en : oe_n};
      if (cur === v || k >= mx) break;
      @(posedge ref_clk);
      k++;
    end
  endtask
  // fast ramp: one step per frame, eight clocks each
  function automatic int ramp(input int v);
    return v * 8;
  endfunction
  function automatic int rec(input int i);
    return i == 1 ? DC_REC : HEAT_REC;
  endfunction
  task automatic give_verdict();
    $display("mismatches=%0d checks=%0d", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    repeat (80000) @(posedge ref_clk);
    n_mismatch++;
    give_verdict();
  end

  initial begin
    seed = 32'h10743470;
    {rst_b, psel, penable, pwrite, supply_ok, rate_err, run, zero} = '0;
    {ot_det, dc_det, oc_det, paddr, pwdata} = '0;
    shutdown_n = 1'b1;
    repeat (4) @(posedge ref_clk);
    rst_b <= 1'b1;
    @(posedge ref_clk);
    rd(IDX_POWER, {24'h0, POWER_RST});
    rd(IDX_CTRL2, {24'h0, CTRL2_RST});
    rd(IDX_VOLUME, {24'h0, VOLUME_RST});
    rd(IDX_CTRL3, {24'h0, CTRL3_RST});
    rd(IDX_ANALOG2, {24'h0, ANALOG2_RST});
    rd(IDX_FAULT, 32'h08);
    rd(IDX_STATUS, 32'h100);
    rd(8'h02, 32'h0);
    ok(slverr_seen === 1'b1);
    supply_ok <= 1'b1;
    rate_err <= 1'b1;
    run <= 1'b1;
    m = 0;
    repeat (3000) begin
      @(posedge ref_clk);
      if (oe_n === 1'b0) m++;
    end
    ok(m >= 1000 && m <= 1400);
    rate_err <= 1'b0;
    vol = 16;
    wr(IDX_VOLUME, 8'h10);
    wr(IDX_CTRL2, 8'hC0);
    wr(IDX_FAULT, 8'h20);
    wr(IDX_ANALOG2, 8'h0A);
    repeat (2) @(posedge ref_clk);
    ok(pu_en === 1'b1);
    chk({30'h0, cur_lim}, 32'h2);
    wait_on(0, 8'h01, 8000, n);
    ok(sw_en === 1'b1);
    for (int i = 0; i < 3; i++) begin
      vol = vol + 1 + ($random(seed) & 15);
      wr(IDX_VOLUME, vol[7:0]);
      wait_on(1, vol[7:0], 2000, n);
      chk({24'h0, level}, vol);
    end
    wr(IDX_CTRL2, 8'hD0);
    wait_on(1, 8'h00, 3000, n);
    ok(level === 8'h00 && sw_en === 1'b1);
    wr(IDX_CTRL2, 8'h80);
    wait_on(1, vol[7:0], 8000, n);
    ok(n >= (vol - 2) * 64 && level === vol[7:0]);
    wr(IDX_CTRL2, 8'hC0);
    wr(IDX_CTRL3, 8'h08);
    zero <= 1'b1;
    wait_on(0, 8'h00, 12000, n);
    ok(n >= int'(IDLE_SAMPLES_1) * 8 - 16 && sw_en === 1'b0);
    zero <= 1'b0;
    wait_on(0, 8'h01, 40, n);
    ok(sw_en === 1'b1);
    wr(IDX_CTRL3, 8'h00);
    for (int k = 0; k < 2; k++) begin
      if (k == 0) rate_err <= 1'b1;
      else run <= 1'b0;
      wait_on(0, 8'h00, 2500, n);
      ok(sw_en === 1'b0 && n <= (k == 0 ? 6 : 2100));
      m = 0;
      repeat (300) begin
        @(posedge ref_clk);
        if (oe_n !== 1'b0) m++;
      end
      ok(m == 0);
      rd(IDX_FAULT, 32'h28);
      rate_err <= 1'b0;
      run <= 1'b1;
      wait_on(1, vol[7:0], 8000, n);
      ok(level === vol[7:0] && oe_n === 1'b1);
    end
    supply_ok <= 1'b0;
    wait_on(0, 8'h00, 10, n);
    ok(sw_en === 1'b0);
    rd(IDX_VOLUME, vol);
    supply_ok <= 1'b1;
    wait_on(1, vol[7:0], 8000, n);
    ok(level === vol[7:0]);
    for (int i = 0; i < 3; i++) begin
      {oc_det, dc_det, ot_det} <= 3'b001 << i;
      wait_on(0, 8'h00, 10, n);
      ok(sw_en === 1'b0);
      {oc_det, dc_det, ot_det} <= 3'b000;
      wr(IDX_POWER, 8'hFF);
      wr(IDX_POWER, 8'hFD);
      ok(oe_n === 1'b0);
      rd(IDX_FAULT, 32'h20 | (32'h1 << i));
      if (i == 1) begin
        wr(IDX_POWER, 8'hFC);
        wr(IDX_POWER, 8'hFD);
      end else begin
        shutdown_n <= 1'b0;
        repeat (8) @(posedge ref_clk);
        shutdown_n <= 1'b1;
      end
      wait_on(2, 8'h01, 3000, n);
      ok(n + 6 >= rec(i) && n <= rec(i) + 20);
      wait_on(0, 8'h01, 6000, m);
      ok(n + m + 8 >= STARTUP_CYC);
      ok(n + m <= STARTUP_CYC + rec(i) + 40);
      ok(level === 8'h00);
      wait_on(1, vol[7:0], 3000, n);
      ok(n + 8 >= ramp(vol) && n <= ramp(vol) + 24);
      rd(IDX_FAULT, 32'h20);
    end
    // sleep bit and shutdown pin while playing both ramp down first
    wr(IDX_POWER, 8'hFF);
    wait_on(0, 8'h00, 3000, n);
    ok(n + 16 >= ramp(vol) && level === 8'h00);
    wr(IDX_POWER, 8'hFD);
    wait_on(1, vol[7:0], 3000, n);
    ok(sw_en === 1'b1);
    shutdown_n <= 1'b0;
    wait_on(0, 8'h00, 3000, n);
    ok(n + 16 >= ramp(vol) && on === 1'b0);
    rst_b <= 1'b0;
    shutdown_n <= 1'b1;
    repeat (4) @(posedge ref_clk);
    rst_b <= 1'b1;
    @(posedge ref_clk);
    rd(IDX_VOLUME, {24'h0, VOLUME_RST});
    ok(sw_en === 1'b0);
    give_verdict();
  end
endmodule
